//--- cpu_exec_defines.vh
// constants for the branch, skip and load execute unit
// assumes: included by bare name from the design files; definitions only
`ifndef CPU_EXEC_DEFINES_VH
`define CPU_EXEC_DEFINES_VH

// register byte offsets on the avalon slave
`define OFS_INSTR     8'h00
`define OFS_EXT       8'h04
`define OFS_FLAGS     8'h08
`define OFS_PC        8'h0C
`define OFS_RSEL      8'h10
`define OFS_RDATA     8'h14
`define OFS_STATUS    8'h18

// flag register bit positions
`define FLG_C         3'h0
`define FLG_Z         3'h1
`define FLG_N         3'h2
`define FLG_V         3'h3
`define FLG_S         3'h4
`define FLG_H         3'h5
`define FLG_T         3'h6
`define FLG_I         3'h7

// reset values
`define RST_FLAGS     8'h00
`define RST_PC        16'h0000

// pointer pair base register numbers
`define PTR_X         5'h1A
`define PTR_Y         5'h1C
`define PTR_Z         5'h1E

// nominal cycle counts
`define CYC_ONE       4'h1
`define CYC_TWO       4'h2

`endif

//--- cmp_flag_unit.v
// compare subtraction and flag generation for the compare instructions
// assumes: purely combinational; caller picks operands and carry use
`timescale 1ns/100ps
`default_nettype none
`include "cpu_exec_defines.vh"
module cmp_flag_unit (
  input  wire [7:0] op_a,
  input  wire [7:0] op_b,
  input  wire       carry_in,
  input  wire       use_carry,
  input  wire       zero_in,
  output reg  [5:0] flags_out
);
  wire [7:0] res;
  wire       n;
  wire       v;

  assign res = op_a - op_b - {7'h00, (use_carry & carry_in)};
  assign n   = res[7];
  assign v   = (op_a[7] & ~op_b[7] & ~res[7]) | (~op_a[7] & op_b[7] & res[7]);

  always @* begin
    flags_out = 6'h00;
    flags_out[`FLG_C] = (~op_a[7] & op_b[7]) | (op_b[7] & res[7]) | (res[7] & ~op_a[7]);
    // with carry, zero can only stay set so multi-byte compares chain
    flags_out[`FLG_Z] = (res == 8'h00) & (use_carry ? zero_in : 1'b1);
    flags_out[`FLG_N] = n;
    flags_out[`FLG_V] = v;
    flags_out[`FLG_S] = n ^ v;
    flags_out[`FLG_H] = (~op_a[3] & op_b[3]) | (op_b[3] & res[3]) | (res[3] & ~op_a[3]);
  end
endmodule // cmp_flag_unit
`default_nettype wire

//--- cpu_branch_skip_load_exec.v
// execute unit for compare/skip, flag branches and simple loads
// assumes: avalon-mm master feeds one instruction word at a time; data and
// i/o space answer reads through mem_rd/mem_ack
// writes stall while an instruction runs; reads take only the one wait state, so status can be polled
`timescale 1ns/100ps
`default_nettype none
`include "cpu_exec_defines.vh"
module cpu_branch_skip_load_exec (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg         mem_rd,
  output reg         mem_io,
  output reg  [15:0] mem_addr,
  input  wire [7:0]  mem_rdata,
  input  wire        mem_ack
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_MEM  = 2'h2;
  localparam ST_WAIT = 2'h3;

  // true for opcodes that carry a second word
  function two_word;
    input [15:0] w;
    begin
      two_word = ((w[15:10] == 6'b100100) & (w[3:0] == 4'h0)) |
                 ((w[15:9] == 7'b1001010) & (w[3:2] == 2'b11));
    end
  endfunction

  // indirect load forms as {valid, post_inc, pre_dec}; x uses low nibble 1100-1110,
  // y 1001-1010 and z 0001-0010, with the plain y and z forms in the 1000000 group
  function [2:0] ld_form;
    input [15:0] w;
    begin
      ld_form = 3'b000;
      if (w[15:9] == 7'b1001000) begin
        case (w[3:0])
          4'hC:             ld_form = 3'b100;
          4'h1, 4'h9, 4'hD: ld_form = 3'b110;
          4'h2, 4'hA, 4'hE: ld_form = 3'b101;
          default:          ld_form = 3'b000;
        endcase
      end else if (w[15:9] == 7'b1000000) begin
        // displacement forms are outside this unit; only a zero displacement loads
        if ((w[3:0] == 4'h0) | (w[3:0] == 4'h8)) begin
          ld_form = 3'b100;
        end
      end
    end
  endfunction

  // flag tested by a branch; the sign slot is formed from n xor v directly
  function flag_pick;
    input [7:0] f;
    input [2:0] s;
    begin
      case (s)
        `FLG_C:  flag_pick = f[`FLG_C];
        `FLG_Z:  flag_pick = f[`FLG_Z];
        `FLG_N:  flag_pick = f[`FLG_N];
        `FLG_V:  flag_pick = f[`FLG_V];
        `FLG_S:  flag_pick = f[`FLG_N] ^ f[`FLG_V];
        `FLG_H:  flag_pick = f[`FLG_H];
        `FLG_T:  flag_pick = f[`FLG_T];
        `FLG_I:  flag_pick = f[`FLG_I];
        default: flag_pick = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0]  gpr [0:31];
  reg  [7:0]  flags;
  reg  [15:0] pc;
  reg  [15:0] instr;
  reg  [15:0] ext;
  reg  [4:0]  rsel;
  reg  [1:0]  state;
  reg  [3:0]  cyc;
  reg  [3:0]  need;
  reg  [3:0]  last_cyc;
  reg         ack_q;
  reg         illegal;
  reg         taken;
  reg  [4:0]  load_dst;
  reg  [4:0]  ptr_base;
  reg         ptr_inc;
  reg         io_want;
  reg  [2:0]  io_bit;
  integer     i;

  wire        busy = (state != ST_IDLE);
  wire        req  = avs_read | avs_write;
  wire        wr_fire = avs_write & ack_q;

  // decode
  wire [4:0]  rd    = instr[8:4];
  wire [4:0]  rr    = {instr[9], instr[3:0]};
  wire [4:0]  rd_hi = {1'b1, instr[7:4]};
  wire [7:0]  imm   = {instr[11:8], instr[3:0]};
  wire [2:0]  bsel  = instr[2:0];
  wire [15:0] koff  = {{9{instr[9]}}, instr[9:3]};
  wire        is_compare_skip_equal = instr[15:10] == 6'b000100;
  wire        is_cp   = instr[15:10] == 6'b000101;
  wire        is_cpc  = instr[15:10] == 6'b000001;
  wire        is_cpi  = instr[15:12] == 4'h3;
  wire        is_mov  = instr[15:10] == 6'b001011;
  wire        is_copy_register_pair = instr[15:8] == 8'h01;
  wire        is_ldi  = instr[15:12] == 4'hE;
  wire        is_sbr  = (instr[15:10] == 6'b111111) & ~instr[3];
  wire        is_sbi  = (instr[15:8] == 8'h99) | (instr[15:8] == 8'h9B);
  wire        is_br   = instr[15:11] == 5'b11110;
  wire        is_lds  = (instr[15:9] == 7'b1001000) & (instr[3:0] == 4'h0);
  wire [2:0]  ld_f     = ld_form(instr);
  wire        is_ld    = ld_f[2];
  wire [4:0]  ptr_sel = (instr[3:2] == 2'b11) ? `PTR_X : (instr[3] ? `PTR_Y : `PTR_Z);
  wire        post_inc = ld_f[1];
  wire        pre_dec  = ld_f[0];
  wire [15:0] ptr_val  = {gpr[ptr_sel + 5'h01], gpr[ptr_sel]};
  wire [15:0] ptr_dec  = ptr_val - 16'h0001;
  wire [15:0] skip_pc  = pc + (two_word(ext) ? 16'h0003 : 16'h0002);
  wire [3:0]  skip_cyc = two_word(ext) ? 4'h3 : `CYC_TWO;

  wire        flag_bit = flag_pick(flags, bsel);
  wire        br_take  = instr[10] ? ~flag_bit : flag_bit;
  wire        reg_bit  = gpr[rd][bsel];
  wire        sbr_take = instr[9] ? reg_bit : ~reg_bit;

  // compares share one subtractor; the immediate form uses the upper sixteen registers
  wire [7:0]  cmp_a = is_cpi ? gpr[rd_hi] : gpr[rd];
  wire [7:0]  cmp_b = is_cpi ? imm : gpr[rr];
  wire [5:0]  cmp_flags;

  cmp_flag_unit u_cmp (
    .op_a      (cmp_a),
    .op_b      (cmp_b),
    .carry_in  (flags[`FLG_C]),
    .use_carry (is_cpc),
    .zero_in   (flags[`FLG_Z]),
    .flags_out (cmp_flags)
  );

  // one wait state on every access; writes also wait while executing
  assign avs_waitrequest = req & ~ack_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q & (avs_read | ~busy);
      if (avs_read & ~ack_q) begin
        case (avs_address)
          `OFS_INSTR:  avs_readdata <= {16'h0000, instr};
          `OFS_EXT:    avs_readdata <= {16'h0000, ext};
          `OFS_FLAGS:  avs_readdata <= {24'h00_0000, flags};
          `OFS_PC:     avs_readdata <= {16'h0000, pc};
          `OFS_RSEL:   avs_readdata <= {27'h000_0000, rsel};
          `OFS_RDATA:  avs_readdata <= {24'h00_0000, gpr[rsel]};
          `OFS_STATUS: avs_readdata <= {24'h00_0000, busy, illegal, taken, 1'b0, last_cyc};
          default:     avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < 32; i = i + 1) begin
        gpr[i] <= 8'h00;
      end
      flags    <= `RST_FLAGS;
      pc       <= `RST_PC;
      instr    <= 16'h0000;
      ext      <= 16'h0000;
      rsel     <= 5'h00;
      state    <= ST_IDLE;
      cyc      <= 4'h0;
      need     <= 4'h0;
      last_cyc <= 4'h0;
      illegal  <= 1'b0;
      taken    <= 1'b0;
      load_dst <= 5'h00;
      ptr_base <= 5'h00;
      ptr_inc  <= 1'b0;
      io_want  <= 1'b0;
      io_bit   <= 3'h0;
      mem_rd   <= 1'b0;
      mem_io   <= 1'b0;
      mem_addr <= 16'h0000;
    end else begin
      if (wr_fire) begin
        case (avs_address)
          `OFS_INSTR: begin
            instr <= avs_writedata[15:0];
            state <= ST_EXEC;
            cyc   <= 4'h1;
          end
          `OFS_EXT:   ext <= avs_writedata[15:0];
          `OFS_FLAGS: flags <= avs_writedata[7:0];
          `OFS_PC:    pc <= avs_writedata[15:0];
          `OFS_RSEL:  rsel <= avs_writedata[4:0];
          `OFS_RDATA: gpr[rsel] <= avs_writedata[7:0];
          default: ;
        endcase
      end
      case (state)
        ST_EXEC: begin
          illegal <= 1'b0;
          taken   <= 1'b0;
          ptr_inc <= 1'b0;
          need    <= `CYC_ONE;
          state   <= ST_WAIT;
          pc      <= pc + 16'h0001;
          // flags only move here for compares
          if (is_cp | is_cpc | is_cpi) begin
            flags[5:0] <= cmp_flags;
          end else if (is_compare_skip_equal) begin
            if (gpr[rd] == gpr[rr]) begin
              pc    <= skip_pc;
              need  <= skip_cyc;
              taken <= 1'b1;
            end
          end else if (is_sbr) begin
            if (sbr_take) begin
              pc    <= skip_pc;
              need  <= skip_cyc;
              taken <= 1'b1;
            end
          end else if (is_br) begin
            if (br_take) begin
              pc    <= pc + koff + 16'h0001;
              need  <= `CYC_TWO;
              taken <= 1'b1;
            end
          end else if (is_mov) begin
            gpr[rd] <= gpr[rr];
          end else if (is_copy_register_pair) begin
            // both bytes of the pair move in the same cycle
            gpr[{instr[7:4], 1'b0}] <= gpr[{instr[3:0], 1'b0}];
            gpr[{instr[7:4], 1'b1}] <= gpr[{instr[3:0], 1'b1}];
          end else if (is_ldi) begin
            gpr[rd_hi] <= imm;
          end else if (is_sbi) begin
            mem_rd   <= 1'b1;
            mem_io   <= 1'b1;
            // io space is 32 locations, so the address field is five bits
            mem_addr <= {11'h000, instr[7:3]};
            io_bit   <= bsel;
            io_want  <= instr[9];
            state    <= ST_MEM;
          end else if (is_lds) begin
            mem_rd   <= 1'b1;
            mem_io   <= 1'b0;
            mem_addr <= ext;
            load_dst <= rd;
            // step past the address word that follows the opcode
            pc       <= pc + 16'h0002;
            need     <= `CYC_TWO;
            state    <= ST_MEM;
          end else if (is_ld) begin
            mem_rd   <= 1'b1;
            mem_io   <= 1'b0;
            load_dst <= rd;
            ptr_base <= ptr_sel;
            ptr_inc  <= post_inc;
            state    <= ST_MEM;
            if (pre_dec) begin
              // pointer moves on the same edge that issues the read at the decremented address
              gpr[ptr_sel]          <= ptr_dec[7:0];
              gpr[ptr_sel + 5'h01]  <= ptr_dec[15:8];
              mem_addr              <= ptr_dec;
              need                  <= `CYC_TWO;
            end else begin
              mem_addr <= ptr_val;
            end
          end else begin
            illegal <= 1'b1;
          end
        end
        ST_MEM: begin
          cyc <= cyc + 4'h1;
          if (mem_ack) begin
            mem_rd <= 1'b0;
            mem_io <= 1'b0;
            state  <= ST_WAIT;
            if (is_sbi) begin
              // i/o skip costs one more than the register form
              if (mem_rdata[io_bit] == io_want) begin
                pc      <= skip_pc - 16'h0001;
                need    <= skip_cyc + 4'h1;
                taken   <= 1'b1;
              end else begin
                need <= `CYC_TWO;
              end
            end else begin
              gpr[load_dst] <= mem_rdata;
              if (ptr_inc) begin
                {gpr[ptr_base + 5'h01], gpr[ptr_base]} <=
                  {gpr[ptr_base + 5'h01], gpr[ptr_base]} + 16'h0001;
              end
            end
          end
        end
        ST_WAIT: begin
          // pad to the nominal count; memory stalls only lengthen it
          // the count is four bits: a stall beyond thirteen cycles wraps last_cyc
          if (cyc >= need) begin
            state    <= ST_IDLE;
            last_cyc <= cyc;
          end else begin
            cyc <= cyc + 4'h1;
          end
        end
        default: ;
      endcase
    end
  end
endmodule // cpu_branch_skip_load_exec
`default_nettype wire

//--- cpu_branch_skip_load_exec_asserts.sv
// port-level checks for the branch, skip and load execute unit
// assumes: bound to the unit; one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module cpu_branch_skip_load_exec_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mem_rd,
  input wire logic        mem_io,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  mem_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr) && $stable(mem_io))
    else $error("memory request moved before its answer");
  mem_drop_a: assert property (mem_rd && mem_ack |=> !mem_rd)
    else $error("memory request held after its answer");
  io_range_a: assert property (mem_rd && mem_io |-> mem_addr < 16'h0020)
    else $error("io read outside the io range");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  read_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered in one cycle");
  one_beat_a: assert property ((avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest || !(avs_read || avs_write))
    else $error("waitrequest low for more than one cycle");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  busy_stall_a: assert property (avs_write && mem_rd |-> avs_waitrequest)
    else $error("write accepted during a memory read");
endmodule // cpu_branch_skip_load_exec_asserts
bind cpu_branch_skip_load_exec cpu_branch_skip_load_exec_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_rd(mem_rd), .mem_io(mem_io),
  .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
`default_nettype wire

//--- mem_model.sv
// data and io space model answering the unit's reads
// assumes: lat cycles of wait per read; data reads return addr low byte ^ 8'h5a
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_io,
  input  wire logic [15:0] mem_addr,
  input  wire logic [3:0]  lat,
  input  wire logic [7:0]  io_val,
  output wire logic [7:0]  mem_rdata,
  output wire logic        mem_ack
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] junk = 8'h3c;
  // data lines toggle outside an answer so stale bytes are never caught
  always @(posedge clk) begin
    junk <= ~junk;
    cnt <= (mem_rd && !mem_ack) ? cnt + 4'h1 : 4'h0;
  end
  assign mem_ack = mem_rd && cnt >= lat;
  assign mem_rdata = mem_ack ? (mem_io ? io_val : mem_addr[7:0] ^ 8'h5a) : junk;
endmodule // mem_model
`default_nettype wire

//--- test_cpu_branch_skip_load_exec.sv
// self-checking bench for the branch, skip and load execute unit
// assumes: mem_model on the memory side; avalon master tasks below
`timescale 1ns/100ps
`default_nettype none
`include "cpu_exec_defines.vh"
module test_cpu_branch_skip_load_exec;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic [7:0]  avs_address = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, mem_rd, mem_io, mem_ack;
  wire  [15:0] mem_addr;
  wire  [7:0]  mem_rdata;
  logic [3:0]  lat = 0;
  logic [7:0]  io_val = 0;
  int          failures = 0;
  int          tests_run = 0;
  logic [31:0] st, pc, fl, q;
  always #2.5 clk = ~clk;
  cpu_branch_skip_load_exec i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_rd(mem_rd), .mem_io(mem_io), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mem_model i_mem (.clk(clk), .mem_rd(mem_rd), .mem_io(mem_io), .mem_addr(mem_addr), .lat(lat),
    .io_val(io_val), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // request held until a rising edge samples waitrequest low; one idle edge between accesses
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic set_reg(input logic [4:0] r, input logic [7:0] v);
    bus(1, `OFS_RSEL, r);
    bus(1, `OFS_RDATA, v);
  endtask
  task automatic get_reg(input logic [4:0] r);
    bus(1, `OFS_RSEL, r);
    bus(0, `OFS_RDATA, 0);
  endtask
  task automatic run(input logic [15:0] p, input logic [7:0] f, input logic [15:0] i, x);
    bus(1, `OFS_PC, p);
    bus(1, `OFS_FLAGS, f);
    bus(1, `OFS_EXT, x);
    bus(1, `OFS_INSTR, i);
    do bus(0, `OFS_STATUS, 0); while (q[7] !== 1'b0);
    st = q;
    bus(0, `OFS_PC, 0);
    pc = q;
    bus(0, `OFS_FLAGS, 0);
    fl = q;
  endtask
  function automatic logic [7:0] sub_f(logic [7:0] a, b, fi, logic uc);
    logic [8:0] r;
    logic v;
    r = {1'b0, a} - b - (uc & fi[0]);
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    return {fi[7:6], (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]), r[7] ^ v, v, r[7],
            (r[7:0] == 0) & (~uc | fi[1]), r[8]};
  endfunction
  task automatic t_branch;
    logic [7:0] f;
    logic b;
    for (int s = 0; s < 8; s++)
      for (int j = 0; j < 3; j++) begin
        f = (j == 0) ? 8'h01 << s : (j == 1) ? ~(8'h01 << s) : 8'h04;
        b = (s == 4) ? f[2] ^ f[3] : f[s];
        for (int c = 0; c < 2; c++) begin
          run(16'h0040, f, {5'b11110, c[0], 7'h7d, s[2:0]}, 0);
          chk("br pc", (b ^ c[0]) ? 16'h003e : 16'h0041, pc);
          chk("br st", (b ^ c[0]) ? 7'h22 : 7'h01, st[6:0]);
          chk("br flags", f, fl);
        end
      end
  endtask
  task automatic t_skip;
    logic [15:0] ops [10] = '{16'h1034, 16'h1035, 16'hfc30, 16'hfc31, 16'hfe31, 16'hfe30,
                              16'h9928, 16'h9929, 16'h9b29, 16'h9b28};
    int s;
    set_reg(3, 8'h5a);
    set_reg(4, 8'h5a);
    set_reg(5, 8'h5b);
    io_val <= 8'h5a;
    for (int i = 0; i < 10; i++)
      for (int w = 0; w < 2; w++) begin
        s = i[0] ? 0 : 1 + w;
        run(16'h0040, 8'hc3, ops[i], w ? 16'h9000 : 16'h0000);
        chk("skip pc", 16'h0041 + s, pc);
        chk("skip cyc", (i > 5 ? 2 : 1) + s, st[3:0]);
        chk("skip flags", 8'hc3, fl);
      end
  endtask
  task automatic t_cmp;
    logic [7:0] a [4] = '{8'h00, 8'h80, 8'h18, 8'h33};
    logic [7:0] b [4] = '{8'h01, 8'h01, 8'h09, 8'h33};
    logic [15:0] ops [3];
    logic [7:0] fi;
    for (int v = 0; v < 4; v++)
      for (int m = 0; m < 3; m++) begin
        fi = ((v + m) % 2) ? 8'hc3 : 8'h3c;
        set_reg(16, a[v]);
        set_reg(17, b[v]);
        ops = '{16'h1701, 16'h0701, {4'h3, b[v][7:4], 4'h0, b[v][3:0]}};
        run(16'h0040, fi, ops[m], 0);
        chk("cmp flags", sub_f(a[v], b[v], fi, m == 1), fl);
        get_reg(16);
        chk("cmp reg", a[v], q);
      end
  endtask
  task automatic t_ld(input logic [15:0] op, x, input logic [4:0] pr, input logic [15:0] pi, po,
                      input logic [4:0] d, input logic [7:0] e, input logic [3:0] c);
    set_reg(pr, pi[7:0]);
    set_reg(pr + 5'h1, pi[15:8]);
    run(16'h0010, 8'ha5, op, x);
    get_reg(d);
    chk("ld data", e, q);
    get_reg(pr);
    chk("ptr lo", po[7:0], q);
    get_reg(pr + 5'h1);
    chk("ptr hi", po[15:8], q);
    chk("ld cyc", c, st[3:0]);
    chk("ld flags", 8'ha5, fl);
  endtask
  task automatic t_loads;
    t_ld(16'h905e, 0, `PTR_X, 16'h0105, 16'h0104, 5, 8'h5e, 2);
    t_ld(16'h906d, 0, `PTR_X, 16'h0104, 16'h0105, 6, 8'h5e, 2);
    t_ld(16'h9080, 16'h2233, `PTR_Z, 0, 0, 8, 8'h69, 2);
    t_ld(16'h2ca5, 0, `PTR_Y, 16'h0700, 16'h0700, 10, 8'h5e, 1);
    t_ld(16'he74e, 0, `PTR_Y, 16'h0100, 16'h0100, 20, 8'h7e, 1);
    t_ld(16'h01ad, 0, `PTR_X, 16'h1234, 16'h1234, 20, 8'h34, 1);
    get_reg(21);
    chk("pair hi", 8'h12, q);
    lat <= 3;
    t_ld(16'h9071, 0, `PTR_Z, 16'h00ff, 16'h0100, 7, 8'ha5, 5);
    t_ld(16'h909a, 0, `PTR_Y, 16'h0100, 16'h00ff, 9, 8'ha5, 5);
  endtask
  task automatic t_illegal;
    run(16'h0040, 8'h5a, 16'h0000, 0);
    chk("undecoded pc", 16'h0041, pc);
    chk("undecoded st", 7'h41, st[6:0]);
    chk("undecoded flags", 8'h5a, fl);
  endtask
  initial begin
    #400_000;
    failures++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    bus(0, `OFS_PC, 0);
    chk("pc reset", 0, q);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, q);
    t_branch;
    t_skip;
    t_cmp;
    t_loads;
    t_illegal;
    wrap_up;
  end
endmodule // test_cpu_branch_skip_load_exec
`default_nettype wire
